// *** hdl/csrb_pkg.sv ***
`default_nettype none
package csrb_pkg;
    // File addresses of the special registers
    localparam logic [7:0] OFF_INDIRECT = 8'h00;
    localparam logic [7:0] OFF_TIMER = 8'h01;
    localparam logic [7:0] OFF_PC_LOW = 8'h02;
    localparam logic [7:0] OFF_FLAGS = 8'h03;
    localparam logic [7:0] OFF_POINTER = 8'h04;
    localparam logic [7:0] OFF_PIN_A = 8'h05;
    localparam logic [7:0] OFF_PIN_B = 8'h06;
    localparam logic [7:0] OFF_PC_HIGH = 8'h0a;
    localparam logic [7:0] OFF_IRQ = 8'h0b;
    localparam logic [7:0] OFF_PRESCALE = 8'h81;
    localparam logic [7:0] OFF_DIR_A = 8'h85;
    localparam logic [7:0] OFF_DIR_B = 8'h86;
    localparam logic [7:0] OFF_POWER = 8'h8e;
    // Mirrored registers ignore the bank bit of the file address
    localparam logic [7:0] BANK_MASK = 8'h7f;

    // Bus address slicing: byte address is four times the file address
    localparam int FILE_LSB = 2;
    localparam int FILE_MSB = 9;
    localparam int RANGE_LSB = 10;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'h0;

    // Reset values
    localparam logic [7:0] DATA_POR = 8'h00;
    localparam logic [7:0] FLAGS_POR = 8'h18;
    localparam logic [7:0] PC_LOW_RST = 8'h00;
    localparam logic [7:0] PC_HIGH_RST = 8'h00;
    localparam logic [7:0] IRQ_RST = 8'h00;
    localparam logic [7:0] PRESCALE_RST = 8'hff;
    localparam logic [7:0] DIR_A_RST = 8'h1f;
    localparam logic [7:0] DIR_B_RST = 8'hff;
    localparam logic [7:0] POWER_POR = 8'h00;

    // Implemented bits
    localparam logic [7:0] PIN_A_MASK = 8'h1f;
    localparam logic [7:0] PC_HIGH_MASK = 8'h1f;
    localparam logic [7:0] IRQ_MASK = 8'hbf;
    localparam logic [7:0] POWER_MASK = 8'h02;

    // Flag register bit positions
    localparam int BIT_CARRY = 0;
    localparam int BIT_ZERO = 2;
    localparam int BIT_PD = 3;
    localparam int BIT_TO = 4;
    localparam int BIT_RP0 = 5;
    localparam int BIT_IRP = 7;
    // Interrupt control bit positions
    localparam int BIT_PIN_GROUP_B_VALUE_IF = 0;
    localparam int BIT_EXT_IF = 1;
    localparam int BIT_TIMER_IF = 2;

    localparam logic [7:0] TIMER_LAST = 8'hff;

    typedef enum logic {
        BUS_IDLE,
        BUS_DATA
    } csrb_bus_state_t;
endpackage
`default_nettype wire

// *** hdl/csrb_sync3.sv ***
`default_nettype none
module csrb_sync3 #(
    parameter logic RST_VAL = 1'h0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic dout_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a change only once two stable stages agree
    always_ff @(posedge clk) begin
        if (rst) begin
            dout_q <= RST_VAL;
        end else if (s2_q == s3_q) begin
            dout_q <= s3_q;
        end
    end

    assign dout = dout_q;
endmodule
`default_nettype wire

// *** hdl/csrb_reset_ctl.sv ***
`default_nettype none
module csrb_reset_ctl (
    input wire logic clk,
    input wire logic rst,
    input wire logic clearPinSyncN,
    input wire logic watchdogTimeout,
    output logic softRst,
    output logic wdtCause
);
    logic softRst_q;
    logic wdtCause_q;

    // Held clear pin keeps the bank in reset for as long as it is low
    always_ff @(posedge clk) begin
        if (rst) begin
            softRst_q <= 1'h0;
            wdtCause_q <= 1'h0;
        end else begin
            softRst_q <= !clearPinSyncN || watchdogTimeout;
            wdtCause_q <= watchdogTimeout;
        end
    end

    assign softRst = softRst_q;
    assign wdtCause = wdtCause_q;
endmodule
`default_nettype wire

// *** hdl/csrb_core_sfr.sv ***
// Contract
// - Unimplemented addresses and unimplemented bits read back as zero.
// - Clear pin or watchdog reset loads the non power-up values.
// - Registers marked unchanged keep contents over a non power-up reset.
// - Non power-up reset clears flag bits 7:5, sets TO/PD by cause.
// - Register contents are static and hold while clock is stopped.
// - ALU flag update overrides written Z/DC/C; TO and PD never writable.
// - Flag register holds bank select, arithmetic flags and reset cause.
`default_nettype none
module csrb_core_sfr
    import csrb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic masterClearPinN,
    input wire logic watchdogTimeout,
    input wire logic clrwdtExec,
    input wire logic sleepExec,
    input wire logic aluFlagUpdate,
    input wire logic [2:0] aluFlags,
    input wire logic timerTick,
    input wire logic extIrqEvent,
    input wire logic portBIrqEvent,
    input wire logic [4:0] pinInA,
    input wire logic [7:0] pinInB,
    output logic [7:0] coreFlags,
    output logic [7:0] indirectPointer,
    output logic [7:0] progCounterLow,
    output logic [7:0] progCounterHighLatch,
    output logic [7:0] irqControl,
    output logic [7:0] prescaleConfig,
    output logic [7:0] timerCount,
    output logic [7:0] pinGroupA,
    output logic [7:0] pinGroupB,
    output logic [7:0] pinDirectionA,
    output logic [7:0] pinDirectionB,
    output logic [7:0] powerFlags
);
    logic clearPinSyncN;
    logic softRst;
    logic wdtCause;
    logic [4:0] pinSyncA;
    logic [7:0] pinSyncB;

    csrb_sync3 #(.RST_VAL(1'h1)) uClearSync (
        .clk(clk),
        .rst(rst),
        .din(masterClearPinN),
        .dout(clearPinSyncN)
    );

    csrb_reset_ctl uResetCtl (
        .clk(clk),
        .rst(rst),
        .clearPinSyncN(clearPinSyncN),
        .watchdogTimeout(watchdogTimeout),
        .softRst(softRst),
        .wdtCause(wdtCause)
    );

    for (genvar i = 0; i < 5; i++) begin : gSyncA
        csrb_sync3 uSync (
            .clk(clk),
            .rst(rst),
            .din(pinInA[i]),
            .dout(pinSyncA[i])
        );
    end

    for (genvar i = 0; i < 8; i++) begin : gSyncB
        csrb_sync3 uSync (
            .clk(clk),
            .rst(rst),
            .din(pinInB[i]),
            .dout(pinSyncB[i])
        );
    end

    function automatic logic hit(input logic [7:0] fa, input logic [7:0] off, input logic mirrored);
        if (mirrored) begin
            hit = (fa & BANK_MASK) == off;
        end else begin
            hit = fa == off;
        end
    endfunction

    // plain flip-flop storage, no dynamic state
    logic [7:0] timer_q;
    logic [7:0] pcLow_q;
    logic [7:0] flags_q;
    logic [7:0] pointer_q;
    logic [7:0] pinA_q;
    logic [7:0] pinB_q;
    logic [7:0] pcHigh_q;
    logic [7:0] irq_q;
    logic [7:0] prescale_q;
    logic [7:0] dirA_q;
    logic [7:0] dirB_q;
    logic [7:0] power_q;

    csrb_bus_state_t busState_q;
    logic [7:0] fileAddr_q;
    logic isWrite_q;
    logic isWord_q;
    logic inRange_q;
    logic hreadyout_q;
    logic [31:0] hrdata_q;
    logic accept;

    assign accept = hsel && hready && (htrans == HTRANS_NONSEQ);

    // One wait state per transfer so a read always sees the previous write
    always_ff @(posedge clk) begin
        if (rst) begin
            busState_q <= BUS_IDLE;
            hreadyout_q <= 1'h1;
            fileAddr_q <= 8'h00;
            isWrite_q <= 1'h0;
            isWord_q <= 1'h0;
            inRange_q <= 1'h0;
        end else begin
            case (busState_q)
                BUS_IDLE: begin
                    if (accept) begin
                        busState_q <= BUS_DATA;
                        hreadyout_q <= 1'h0;
                        fileAddr_q <= haddr[FILE_MSB:FILE_LSB];
                        isWrite_q <= hwrite;
                        isWord_q <= hsize == HSIZE_WORD;
                        inRange_q <= haddr[31:RANGE_LSB] == 22'h000000;
                    end
                end
                BUS_DATA: begin
                    busState_q <= BUS_IDLE;
                    hreadyout_q <= 1'h1;
                end
                default: begin
                    busState_q <= BUS_IDLE;
                    hreadyout_q <= 1'h1;
                end
            endcase
        end
    end

    // Indirect location resolves through the pointer; pointing at itself is null
    logic viaIndirect;
    logic [7:0] effAddr;
    logic effValid;
    always_comb begin
        viaIndirect = hit(fileAddr_q, OFF_INDIRECT, 1'h1);
        effAddr = viaIndirect ? pointer_q : fileAddr_q;
        effValid = inRange_q && !(viaIndirect && hit(pointer_q, OFF_INDIRECT, 1'h1));
    end

    logic wrEn;
    logic [7:0] wrData;
    assign wrEn = (busState_q == BUS_DATA) && isWrite_q && isWord_q && effValid && !softRst;
    assign wrData = hwdata[7:0];

    logic wrTimer;
    logic wrPcLow;
    logic wrFlags;
    logic wrPointer;
    logic wrPinA;
    logic wrPinB;
    logic wrPcHigh;
    logic wrIrq;
    logic wrPrescale;
    logic wrDirA;
    logic wrDirB;
    logic wrPower;
    always_comb begin
        wrTimer = wrEn && hit(effAddr, OFF_TIMER, 1'h0);
        wrPcLow = wrEn && hit(effAddr, OFF_PC_LOW, 1'h1);
        wrFlags = wrEn && hit(effAddr, OFF_FLAGS, 1'h1);
        wrPointer = wrEn && hit(effAddr, OFF_POINTER, 1'h1);
        wrPinA = wrEn && hit(effAddr, OFF_PIN_A, 1'h0);
        wrPinB = wrEn && hit(effAddr, OFF_PIN_B, 1'h0);
        wrPcHigh = wrEn && hit(effAddr, OFF_PC_HIGH, 1'h1);
        wrIrq = wrEn && hit(effAddr, OFF_IRQ, 1'h1);
        wrPrescale = wrEn && hit(effAddr, OFF_PRESCALE, 1'h0);
        wrDirA = wrEn && hit(effAddr, OFF_DIR_A, 1'h0);
        wrDirB = wrEn && hit(effAddr, OFF_DIR_B, 1'h0);
        wrPower = wrEn && hit(effAddr, OFF_POWER, 1'h0);
    end

    logic [7:0] readValue;
    always_comb begin
        readValue = 8'h00;
        if (!effValid) begin
            readValue = 8'h00;
        end else if (hit(effAddr, OFF_TIMER, 1'h0)) begin
            readValue = timer_q;
        end else if (hit(effAddr, OFF_PC_LOW, 1'h1)) begin
            readValue = pcLow_q;
        end else if (hit(effAddr, OFF_FLAGS, 1'h1)) begin
            readValue = flags_q;
        end else if (hit(effAddr, OFF_POINTER, 1'h1)) begin
            readValue = pointer_q;
        end else if (hit(effAddr, OFF_PIN_A, 1'h0)) begin
            readValue = {3'h0, pinSyncA};
        end else if (hit(effAddr, OFF_PIN_B, 1'h0)) begin
            readValue = pinSyncB;
        end else if (hit(effAddr, OFF_PC_HIGH, 1'h1)) begin
            readValue = pcHigh_q & PC_HIGH_MASK;
        end else if (hit(effAddr, OFF_IRQ, 1'h1)) begin
            readValue = irq_q & IRQ_MASK;
        end else if (hit(effAddr, OFF_PRESCALE, 1'h0)) begin
            readValue = prescale_q;
        end else if (hit(effAddr, OFF_DIR_A, 1'h0)) begin
            readValue = dirA_q & PIN_A_MASK;
        end else if (hit(effAddr, OFF_DIR_B, 1'h0)) begin
            readValue = dirB_q;
        end else if (hit(effAddr, OFF_POWER, 1'h0)) begin
            readValue = power_q & POWER_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata_q <= 32'h00000000;
        end else if (busState_q == BUS_DATA && !isWrite_q) begin
            hrdata_q <= {24'h000000, readValue};
        end
    end

    // timer keeps its count over a soft reset
    always_ff @(posedge clk) begin
        if (rst) begin
            timer_q <= DATA_POR;
        end else if (wrTimer) begin
            timer_q <= wrData;
        end else if (timerTick && !softRst) begin
            timer_q <= timer_q + 8'h01;
        end
    end

    // program counter low clears on every reset
    always_ff @(posedge clk) begin
        if (rst || softRst) begin
            pcLow_q <= PC_LOW_RST;
        end else if (wrPcLow) begin
            pcLow_q <= wrData;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || softRst) begin
            pcHigh_q <= PC_HIGH_RST;
        end else if (wrPcHigh) begin
            pcHigh_q <= wrData & PC_HIGH_MASK;
        end
    end

    // bank select, reset cause and arithmetic flags in one register
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_q <= FLAGS_POR;
        end else if (softRst) begin
            // upper bits cleared, cause in TO/PD
            flags_q[BIT_IRP:BIT_RP0] <= 3'h0;
            if (wdtCause) begin
                flags_q[BIT_TO] <= 1'h0;
                flags_q[BIT_PD] <= 1'h1;
            end
        end else begin
            // bits 7:6 stored as written, software keeps them zero
            if (wrFlags) begin
                flags_q[BIT_IRP:BIT_RP0] <= wrData[BIT_IRP:BIT_RP0];
            end
            // ALU result wins over the data write
            if (aluFlagUpdate) begin
                flags_q[BIT_ZERO:BIT_CARRY] <= aluFlags;
            end else if (wrFlags) begin
                flags_q[BIT_ZERO:BIT_CARRY] <= wrData[BIT_ZERO:BIT_CARRY];
            end
            // TO and PD follow only the core's instructions
            if (clrwdtExec) begin
                flags_q[BIT_TO] <= 1'h1;
                flags_q[BIT_PD] <= 1'h1;
            end else if (sleepExec) begin
                flags_q[BIT_TO] <= 1'h1;
                flags_q[BIT_PD] <= 1'h0;
            end
        end
    end

    // pointer and port latches ignore the soft reset
    always_ff @(posedge clk) begin
        if (rst) begin
            pointer_q <= DATA_POR;
        end else if (wrPointer) begin
            pointer_q <= wrData;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pinA_q <= DATA_POR;
        end else if (wrPinA) begin
            pinA_q <= wrData & PIN_A_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pinB_q <= DATA_POR;
        end else if (wrPinB) begin
            pinB_q <= wrData;
        end
    end

    // Event flags: a set in the same cycle as a software clear wins
    logic timerWrap;
    assign timerWrap = timerTick && !wrTimer && !softRst && (timer_q == TIMER_LAST);

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_q <= IRQ_RST;
        end else if (softRst) begin
            irq_q <= {IRQ_RST[7:1], irq_q[BIT_PIN_GROUP_B_VALUE_IF]};
        end else begin
            if (wrIrq) begin
                irq_q <= wrData & IRQ_MASK;
            end
            if (timerWrap) begin
                irq_q[BIT_TIMER_IF] <= 1'h1;
            end
            if (extIrqEvent) begin
                irq_q[BIT_EXT_IF] <= 1'h1;
            end
            if (portBIrqEvent) begin
                irq_q[BIT_PIN_GROUP_B_VALUE_IF] <= 1'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || softRst) begin
            prescale_q <= PRESCALE_RST;
        end else if (wrPrescale) begin
            prescale_q <= wrData;
        end
    end

    // Pins come up as inputs on every reset
    always_ff @(posedge clk) begin
        if (rst || softRst) begin
            dirA_q <= DIR_A_RST;
        end else if (wrDirA) begin
            dirA_q <= wrData & PIN_A_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || softRst) begin
            dirB_q <= DIR_B_RST;
        end else if (wrDirB) begin
            dirB_q <= wrData;
        end
    end

    // Power flag clears only at power-up; software sets it to detect the next one
    always_ff @(posedge clk) begin
        if (rst) begin
            power_q <= POWER_POR;
        end else if (wrPower) begin
            power_q <= wrData & POWER_MASK;
        end
    end

    assign hreadyout = hreadyout_q;
    assign hresp = HRESP_OKAY;
    assign hrdata = hrdata_q;
    assign coreFlags = flags_q;
    assign indirectPointer = pointer_q;
    assign progCounterLow = pcLow_q;
    assign progCounterHighLatch = pcHigh_q;
    assign irqControl = irq_q;
    assign prescaleConfig = prescale_q;
    assign timerCount = timer_q;
    assign pinGroupA = pinA_q;
    assign pinGroupB = pinB_q;
    assign pinDirectionA = dirA_q;
    assign pinDirectionB = dirB_q;
    assign powerFlags = power_q;
endmodule
`default_nettype wire

// *** testbench/csrb_core_sfr_sva.sv ***
`default_nettype none
module csrb_core_sfr_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic watchdogTimeout,
    input wire logic clrwdtExec,
    input wire logic sleepExec,
    input wire logic aluFlagUpdate,
    input wire logic [2:0] aluFlags,
    input wire logic [7:0] coreFlags,
    input wire logic [7:0] indirectPointer,
    input wire logic [7:0] progCounterLow,
    input wire logic [7:0] prescaleConfig,
    input wire logic [7:0] pinDirectionA,
    input wire logic [7:0] pinDirectionB,
    input wire logic [7:0] pinGroupB,
    input wire logic [7:0] irqControl
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_hresp_okay;
        hresp == 1'b0;
    endproperty
    a_hresp_okay: assert property (p_hresp_okay) else $error("hresp not okay");
    property p_rdata_upper;
        hrdata[31:8] == 24'h0;
    endproperty
    a_rdata_upper: assert property (p_rdata_upper) else $error("read data upper bits set");
    property p_irq_reserved;
        irqControl[6] == 1'b0;
    endproperty
    a_irq_reserved: assert property (p_irq_reserved) else $error("irq bit 6 set");
    // One wait state per transfer, then ready again
    property p_one_wait;
        hsel && hready && htrans == 2'h2 |=> !hreadyout ##1 hreadyout;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("transfer wait state wrong");
    property p_alu_wins;
        aluFlagUpdate && !watchdogTimeout |=> coreFlags[2:0] == $past(aluFlags);
    endproperty
    a_alu_wins: assert property (p_alu_wins) else $error("alu flags not loaded");
    property p_clrwdt;
        clrwdtExec && !watchdogTimeout |=> coreFlags[4:3] == 2'b11;
    endproperty
    a_clrwdt: assert property (p_clrwdt) else $error("clear watchdog flags wrong");
    property p_sleep;
        sleepExec && !clrwdtExec && !watchdogTimeout |=> coreFlags[4:3] == 2'b10;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
    property p_wdt_flags;
        watchdogTimeout |-> ##2 coreFlags[7:3] == 5'b00001;
    endproperty
    a_wdt_flags: assert property (p_wdt_flags) else $error("watchdog reset flags wrong");
    property p_wdt_regs;
        watchdogTimeout |-> ##2 (progCounterLow == 8'h00 && prescaleConfig == 8'hff
            && pinDirectionA == 8'h1f && pinDirectionB == 8'hff);
    endproperty
    a_wdt_regs: assert property (p_wdt_regs) else $error("watchdog reset values wrong");
    property p_wdt_keep;
        watchdogTimeout |-> ##2 (indirectPointer == $past(indirectPointer, 2) && pinGroupB == $past(pinGroupB, 2)
            && (coreFlags & 8'h07) == ($past(coreFlags, 2) & 8'h07));
    endproperty
    a_wdt_keep: assert property (p_wdt_keep) else $error("watchdog reset lost contents");
endmodule

bind csrb_core_sfr csrb_core_sfr_sva u_sva (.clk, .rst, .hsel, .htrans, .hready, .hreadyout, .hresp, .hrdata,
    .watchdogTimeout, .clrwdtExec, .sleepExec, .aluFlagUpdate, .aluFlags, .coreFlags, .indirectPointer,
    .progCounterLow, .prescaleConfig, .pinDirectionA, .pinDirectionB, .pinGroupB, .irqControl);
`default_nettype wire

// *** testbench/csrb_core_model.sv ***
`default_nettype none
module csrb_core_model (
    input wire logic clk,
    output logic aluFlagUpdate,
    output logic [2:0] aluFlags,
    output logic clrwdtExec,
    output logic sleepExec,
    output logic timerTick,
    output logic extIrqEvent,
    output logic portBIrqEvent,
    output logic watchdogTimeout
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] strobeQ;
    initial begin
        strobeQ = 7'h0;
        aluFlags = 3'h0;
    end
    assign {watchdogTimeout, portBIrqEvent, extIrqEvent, timerTick, sleepExec, clrwdtExec, aluFlagUpdate} = strobeQ;
    // Single-cycle strobes, one per executed instruction; never two at once
    task automatic pulse(input int k, input logic [2:0] f);
        @(posedge clk);
        aluFlags <= f;
        strobeQ <= 7'h1 << k;
        @(posedge clk);
        strobeQ <= 7'h0;
    endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`default_nettype none
module tb_top
    import csrb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, hsel, hwrite, hreadyout, hresp, masterClearPinN;
    logic [1:0] htrans;
    logic [2:0] hsize, aluFlags;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    logic [4:0] pinInA;
    logic [7:0] pinInB, coreFlags, indirectPointer, progCounterLow, progCounterHighLatch, irqControl;
    logic [7:0] prescaleConfig, timerCount, pinGroupA, pinGroupB, pinDirectionA, pinDirectionB, powerFlags;
    logic aluFlagUpdate, clrwdtExec, sleepExec, timerTick, extIrqEvent, portBIrqEvent, watchdogTimeout;
    int failCount = 0;
    int nTests = 0;

    csrb_core_sfr DUT (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .masterClearPinN, .watchdogTimeout, .clrwdtExec, .sleepExec, .aluFlagUpdate,
        .aluFlags, .timerTick, .extIrqEvent, .portBIrqEvent, .pinInA, .pinInB, .coreFlags, .indirectPointer,
        .progCounterLow, .progCounterHighLatch, .irqControl, .prescaleConfig, .timerCount, .pinGroupA,
        .pinGroupB, .pinDirectionA, .pinDirectionB, .powerFlags);
    csrb_core_model CORE (.clk, .aluFlagUpdate, .aluFlags, .clrwdtExec, .sleepExec, .timerTick, .extIrqEvent,
        .portBIrqEvent, .watchdogTimeout);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic end_sim;
        if (failCount == 0 && nTests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            failCount++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Sampled at the falling edge so the value equals what the next rising edge sees
    task automatic wait_ready(output logic [31:0] r);
        logic rdy;
        do begin
            @(negedge clk);
            rdy = hreadyout;
            r = hrdata;
            @(posedge clk);
        end while (rdy !== 1'b1);
    endtask

    task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d, input logic [2:0] sz,
        output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= sz;
        wait_ready(r);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_ready(r);
    endtask

    task automatic wr(input logic [7:0] fa, input logic [7:0] d);
        xfer(1'b1, {22'h0, fa, 2'h0}, d, HSIZE_WORD, rdat);
    endtask

    task automatic rc(input logic [7:0] fa, input logic [7:0] e);
        xfer(1'b0, {22'h0, fa, 2'h0}, 8'h00, HSIZE_WORD, rdat);
        chk($sformatf("file %h", fa), rdat, {24'h0, e});
    endtask

    task automatic t_por;
        logic [15:0] tbl [10] = '{16'h0318, 16'h0200, 16'h0a00, 16'h0b00, 16'h81ff, 16'h851f, 16'h86ff,
            16'h8e00, 16'h0400, 16'h0100};
        foreach (tbl[i]) rc(tbl[i][15:8], tbl[i][7:0]);
    endtask

    task automatic t_unimpl;
        rc(8'h07, 8'h00);
        rc(8'h0c, 8'h00);
        rc(8'h8f, 8'h00);
        rc(8'h20, 8'h00);
        rc(8'h05, 8'h15);
        rc(8'h06, 8'ha5);
        wr(8'h0a, 8'hff);
        chk("pc high", 32'(progCounterHighLatch), 32'h1f);
        // Byte-wide write must be dropped
        xfer(1'b1, 32'h28, 8'h07, 3'h0, rdat);
        rc(8'h8a, 8'h1f);
        wr(8'h8e, 8'hff);
        chk("power", 32'(powerFlags), 32'h02);
        rc(8'h8e, 8'h02);
        xfer(1'b1, 32'h40c, 8'hff, HSIZE_WORD, rdat);
        xfer(1'b0, 32'h40c, 8'h00, HSIZE_WORD, rdat);
        chk("unmapped", rdat, 32'h0);
        rc(8'h03, 8'h18);
        wr(8'h0a, 8'h00);
    endtask

    task automatic t_mirror;
        wr(8'h84, 8'h0a);
        rc(8'h04, 8'h0a);
        wr(8'h80, 8'h15);
        rc(8'h8a, 8'h15);
        wr(8'h82, 8'h33);
        rc(8'h02, 8'h33);
        wr(8'h8b, 8'h80);
        rc(8'h0b, 8'h80);
        wr(8'h0b, 8'h00);
    endtask

    task automatic t_flags;
        wr(8'h83, 8'h27);
        rc(8'h03, 8'h3f);
        CORE.pulse(0, 3'b010);
        @(negedge clk);
        chk("alu flags", 32'(coreFlags), 32'h3a);
        CORE.pulse(2, 3'b010);
        @(negedge clk);
        chk("sleep flags", 32'(coreFlags), 32'h32);
        CORE.pulse(1, 3'b010);
        @(negedge clk);
        chk("clrwdt flags", 32'(coreFlags), 32'h3a);
    endtask

    task automatic t_wdt;
        wr(8'h04, 8'h5a);
        wr(8'h81, 8'h00);
        wr(8'h85, 8'h00);
        wr(8'h86, 8'h00);
        wr(8'h02, 8'h55);
        wr(8'h06, 8'h3c);
        wr(8'h05, 8'hff);
        wr(8'h01, 8'h10);
        for (int k = 3; k < 7; k++) CORE.pulse(k, 3'b010);
        repeat (3) @(negedge clk);
        chk("wdt flags", 32'(coreFlags), 32'h0a);
        chk("pc low", 32'(progCounterLow), 32'h0);
        chk("prescale", 32'(prescaleConfig), 32'hff);
        chk("dir a", 32'(pinDirectionA), 32'h1f);
        chk("dir b", 32'(pinDirectionB), 32'hff);
        chk("irq", 32'(irqControl), 32'h01);
        chk("timer", 32'(timerCount), 32'h11);
        chk("pointer", 32'(indirectPointer), 32'h5a);
        chk("port b", 32'(pinGroupB), 32'h3c);
        chk("port a", 32'(pinGroupA), 32'h1f);
        chk("pc high rst", 32'(progCounterHighLatch), 32'h00);
        repeat (40) @(posedge clk);
        chk("idle pointer", 32'(indirectPointer), 32'h5a);
    endtask

    task automatic t_clear;
        wr(8'h81, 8'h00);
        wr(8'h83, 8'h22);
        masterClearPinN <= 1'b0;
        repeat (8) @(posedge clk);
        masterClearPinN <= 1'b1;
        repeat (8) @(negedge clk);
        chk("pin flags", 32'(coreFlags), 32'h0a);
        chk("pin prescale", 32'(prescaleConfig), 32'hff);
        rc(8'h84, 8'h5a);
    endtask

    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
        masterClearPinN = 1'b1;
        pinInA = 5'h15;
        pinInB = 8'ha5;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_por;
        t_unimpl;
        t_mirror;
        t_flags;
        t_wdt;
        t_clear;
        end_sim;
    end

    // Whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        failCount++;
        end_sim;
    end
endmodule
`default_nettype wire
